// file: rtl/capture_ctrl.sv
// Image capture and trigger sequencer with an AHB-Lite register slave.
//
// The implementer's own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "capture_ctrl_defs.svh"
module capture_ctrl
    import capture_ctrl_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic [31:0]       hrdata,
    output logic              hreadyout,
    output logic              hresp,
    input  wire trig_inputs_t trig_in,
    output logic              exposing,
    output logic              readout_busy,
    output logic              frame_done
);
    // *****************************************************************
    // Register bus
    // *****************************************************************
    logic [7:0]     wr_addr_q;
    logic           wr_pend_q;
    capture_mode_t  mode_q;
    logic [CNT_W-1:0] multi_cnt_q, burst_cnt_q;
    logic           rate_man_q;
    logic [15:0]    rate_req_q, rate_act_q;
    logic           gated_exp_q;
    auto_exposure_t ae_q;
    logic [23:0]    exp_us_q, delay_us_q[3];
    trig_type_t     tsel_q;
    trig_cfg_t      tcfg_q[3];
    logic           burst_end_en_q;
    logic           begin_cmd_q, end_cmd_q, soft_q;
    cap_state_t     state_q;
    logic [CNT_W-1:0] left_q;
    logic [15:0]    ae_cnt_q;

    wire wr = wr_pend_q;
    wire [31:0] wd = hwdata;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= hsel && htrans[1] && hwrite;
            wr_addr_q <= haddr[7:0];
        end
    end

    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        case (a)
            `OFS_MODE:      rd_mux = {26'h0, gated_exp_q, rate_man_q,
                                      ae_q, mode_q};
            `OFS_MULTI_CNT: rd_mux = 32'(multi_cnt_q);
            `OFS_BURST_CNT: rd_mux = 32'(burst_cnt_q);
            `OFS_RATE_CTRL: rd_mux = {31'h0, rate_man_q};
            `OFS_RATE_REQ:  rd_mux = {16'h0, rate_req_q};
            `OFS_RATE_ACT:  rd_mux = {16'h0, rate_act_q};
            `OFS_EXPOSURE:  rd_mux = {8'h0, exp_us_q};
            `OFS_TRIG_SEL:  rd_mux = {29'h0, burst_end_en_q, tsel_q};
            `OFS_TRIG_CFG:  rd_mux = {23'h0, tcfg_q[tsel_q]};
            `OFS_TRIG_DELAY: rd_mux = {8'h0, delay_us_q[tsel_q]};
            `OFS_STATUS:    rd_mux = {12'h0, 16'(left_q), 1'b0, active_q,
                                      state_q};
            default:        rd_mux = 32'h0;
        endcase
    endfunction

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready && hsel && htrans[1] && !hwrite)
                hrdata <= rd_mux(haddr[7:0]);
        end
    end

    // Configuration writes; the selector routes per-type settings.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= CAP_CONT;
            multi_cnt_q <= CNT_W'(`RST_MULTI_CNT);
            burst_cnt_q <= CNT_W'(`RST_BURST_CNT);
            rate_man_q <= 1'b0;
            rate_req_q <= `RST_RATE_REQ;
            gated_exp_q <= 1'b0;
            ae_q <= AE_CONT;
            exp_us_q <= `RST_EXPOSURE_US;
            tsel_q <= TT_BEGIN;
            burst_end_en_q <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                tcfg_q[i] <= '{1'b0, 4'h0, QL_RISE, 1'b0};
                delay_us_q[i] <= `RST_DELAY_US;
            end
        end else begin
            if (ae_q == AE_ONCE && ae_cnt_q == `AUTO_ONCE_CYC)
                ae_q <= AE_OFF;
            if (wr) begin
                unique case (wr_addr_q)
                    `OFS_MODE: begin
                        mode_q <= capture_mode_t'(wd[1:0]);
                        ae_q <= auto_exposure_t'(wd[3:2]);
                        rate_man_q <= wd[4];
                        gated_exp_q <= wd[5];
                    end
                    `OFS_MULTI_CNT: multi_cnt_q <= wd[CNT_W-1:0];
                    `OFS_BURST_CNT: burst_cnt_q <= wd[CNT_W-1:0];
                    `OFS_RATE_CTRL: rate_man_q <= wd[0];
                    `OFS_RATE_REQ:  rate_req_q <= wd[15:0];
                    `OFS_EXPOSURE:  exp_us_q <= wd[23:0];
                    `OFS_TRIG_SEL: begin
                        tsel_q <= trig_type_t'(wd[1:0]);
                        burst_end_en_q <= wd[2];
                    end
                    `OFS_TRIG_CFG:  tcfg_q[tsel_q] <= wd[8:0];
                    `OFS_TRIG_DELAY: delay_us_q[tsel_q] <= wd[23:0];
                    default: ;
                endcase
            end
        end
    end

    // Command pulses are one cycle wide.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            begin_cmd_q <= 1'b0;
            end_cmd_q <= 1'b0;
            soft_q <= 1'b0;
        end else begin
            begin_cmd_q <= wr && wr_addr_q == `OFS_COMMAND
                           && wd[`CMD_BEGIN_BIT];
            end_cmd_q <= wr && wr_addr_q == `OFS_COMMAND
                         && wd[`CMD_END_BIT];
            soft_q <= wr && wr_addr_q == `OFS_COMMAND
                      && wd[`CMD_SOFT_BIT];
        end
    end

    // *****************************************************************
    // Trigger qualification
    // *****************************************************************
    trig_cfg_t act;
    logic [1:0] act_type;
    logic raw, raw_q, qual_evt, trig_level;
    logic [CNT_W-1:0] exp_cnt_d;

    always_comb begin
        act_type = 2'd0;
        if (tcfg_q[TT_FRAME].enable) act_type = 2'd1;
        if (tcfg_q[TT_BURST].enable) act_type = 2'd2;
        act = tcfg_q[act_type];
        unique case (act.origin[3:2])
            2'b00: raw = trig_in.lines[act.origin[1:0]];
            2'b01: raw = trig_in.user_out[act.origin[1:0]];
            2'b10: raw = trig_in.counter_evt[act.origin[1:0]];
            2'b11: raw = act.origin[1] ? soft_q
                         : trig_in.logic_blk[act.origin[0]];
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) raw_q <= 1'b0;
        else raw_q <= raw;
    end

    always_comb begin
        trig_level = (act.qual == QL_LOW) ? !raw : raw;
        unique case (act.qual)
            QL_LOW:  qual_evt = !raw;
            QL_HIGH: qual_evt = raw;
            QL_FALL: qual_evt = raw_q && !raw;
            QL_RISE: qual_evt = !raw_q && raw;
            QL_ANY:  qual_evt = raw_q != raw;
            default: qual_evt = 1'b0;
        endcase
        // Count of images one event grants.
        unique case (mode_q)
            CAP_SINGLE: exp_cnt_d = CNT_W'(1);
            CAP_MULTI:  exp_cnt_d = multi_cnt_q;
            default:    exp_cnt_d = (act_type == 2'd2 && !burst_end_en_q)
                                    ? burst_cnt_q : CNT_W'(1);
        endcase
    end

    // *****************************************************************
    // Capture sequencer
    // *****************************************************************
    logic        active_q;   // begin seen, not ended
    logic [31:0] tmr_q, frame_tmr_q, period_q;
    logic [15:0] ro_q;
    wire trig_on = act.enable;
    wire accept  = trig_on && qual_evt
                   && (!readout_busy || act.overlap);
    wire [31:0] delay_cyc = delay_us_q[act_type] * `US_CYCLES;
    wire [31:0] exp_cyc = exp_us_q * `US_CYCLES;
    wire [31:0] frame_cyc = rate_man_q && rate_req_q != 16'h0
        ? `ONE_HZ_CYCLES / {16'h0, rate_req_q} : exp_cyc;
    wire [31:0] rate_full = period_q == 32'h0 ? 32'h0
        : `ONE_HZ_CYCLES / period_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_IDLE;
            active_q <= 1'b0;
            left_q <= '0;
            tmr_q <= 32'h0;
            exposing <= 1'b0;
            frame_done <= 1'b0;
        end else begin
            frame_done <= 1'b0;
            if (end_cmd_q) begin
                state_q <= ST_IDLE;
                active_q <= 1'b0;
                left_q <= '0;
                exposing <= 1'b0;
            end else unique case (state_q)
                ST_IDLE: if (begin_cmd_q) begin
                    active_q <= 1'b1;
                    state_q <= ST_ARMED;
                    left_q <= trig_on ? '0
                        : (mode_q == CAP_SINGLE ? CNT_W'(1)
                                                : multi_cnt_q);
                end
                ST_ARMED: if (accept && left_q == '0) begin
                    left_q <= (act_type == 2'd1 && mode_q == CAP_CONT)
                              ? CNT_W'(1) : exp_cnt_d;
                    tmr_q <= delay_cyc;
                    state_q <= ST_DELAY;
                end else if ((!trig_on || left_q != '0)
                             && frame_tmr_q == 32'h0 && !frame_done) begin
                    // Pacing waits until the frame timer counts down to zero after a frame.
                    tmr_q <= exp_cyc;
                    exposing <= 1'b1;
                    state_q <= ST_EXPOSE;
                end
                ST_DELAY: if (tmr_q == 32'h0) begin
                    tmr_q <= exp_cyc;
                    exposing <= 1'b1;
                    state_q <= ST_EXPOSE;
                end else tmr_q <= tmr_q - 32'h1;
                ST_EXPOSE: if (gated_exp_q ? !trig_level
                                            : tmr_q <= 32'h1) begin
                    exposing <= 1'b0;
                    frame_done <= 1'b1;
                    if (left_q == CNT_W'(1) && mode_q != CAP_CONT
                        && act_type != 2'd2) begin
                        state_q <= ST_IDLE;
                        active_q <= 1'b0;
                        left_q <= '0;
                    end else begin
                        state_q <= ST_ARMED;
                        if (!(mode_q == CAP_CONT
                              && (!trig_on || act_type == 2'd0)))
                            left_q <= left_q - CNT_W'(1);
                    end
                end else tmr_q <= tmr_q - 32'h1;
            endcase
        end
    end

    // Readout window and frame pacing; the actual rate follows the period.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ro_q <= 16'h0;
            readout_busy <= 1'b0;
            frame_tmr_q <= 32'h0;
            period_q <= 32'h0;
            rate_act_q <= 16'h0;
            ae_cnt_q <= 16'h0;
        end else begin
            if (frame_done) begin
                ro_q <= `READOUT_CYCLES;
                readout_busy <= 1'b1;
                frame_tmr_q <= frame_cyc > exp_cyc
                               ? frame_cyc - exp_cyc : 32'h0;
            end else begin
                if (ro_q != 16'h0) ro_q <= ro_q - 16'h1;
                readout_busy <= ro_q > 16'h1;
                if (frame_tmr_q != 32'h0)
                    frame_tmr_q <= frame_tmr_q - 32'h1;
            end
            period_q <= frame_cyc > exp_cyc ? frame_cyc : exp_cyc;
            rate_act_q <= rate_full[31:16] != 16'h0 ? 16'hffff
                          : rate_full[15:0];
            ae_cnt_q <= ae_q == AE_ONCE ? ae_cnt_q + 16'h1 : 16'h0;
        end
    end

    a_once_clears: assert property (@(posedge hclk) disable iff (!hresetn)
        ae_q == AE_ONCE && ae_cnt_q == `AUTO_ONCE_CYC
        && !(wr && wr_addr_q == `OFS_MODE) |=> ae_q == AE_OFF)
        else $error("Auto once did not return to off.");
    a_end_idles: assert property (@(posedge hclk) disable iff (!hresetn)
        end_cmd_q |=> state_q == ST_IDLE && !exposing)
        else $error("End command did not idle the sequencer.");
    a_begin_arms: assert property (@(posedge hclk) disable iff (!hresetn)
        begin_cmd_q && state_q == ST_IDLE && !end_cmd_q
        |=> state_q == ST_ARMED)
        else $error("Begin command did not arm capture.");
    a_trig_off_ign: assert property (@(posedge hclk) disable iff (!hresetn)
        state_q == ST_ARMED && trig_on == 1'b0 |=> state_q != ST_DELAY)
        else $error("Disabled trigger started a delay.");
    a_overlap_drop: assert property (@(posedge hclk) disable iff (!hresetn)
        state_q == ST_ARMED && readout_busy && !act.overlap && !end_cmd_q
        && trig_on |=> state_q != ST_DELAY)
        else $error("Trigger taken during readout with overlap off.");
    a_single_stops: assert property (@(posedge hclk) disable iff (!hresetn)
        frame_done && mode_q == CAP_SINGLE && !trig_on && !end_cmd_q
        |-> state_q == ST_IDLE)
        else $error("Single capture did not stop.");
    a_delay_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        state_q == ST_DELAY && tmr_q != 32'h0 && !end_cmd_q |=> !exposing)
        else $error("Exposure began before delay ended.");
    a_timed_expo: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(exposing) && !gated_exp_q && exp_cyc > 32'h2
        |=> exposing)
        else $error("Timed exposure ended early.");

endmodule // capture_ctrl

// file: rtl/capture_ctrl_defs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef CAPTURE_CTRL_DEFS_SVH
`define CAPTURE_CTRL_DEFS_SVH
`define OFS_MODE        8'h00
`define OFS_COMMAND     8'h04
`define OFS_MULTI_CNT   8'h08
`define OFS_BURST_CNT   8'h0c
`define OFS_RATE_CTRL   8'h10
`define OFS_RATE_REQ    8'h14
`define OFS_RATE_ACT    8'h18
`define OFS_EXPOSURE    8'h1c
`define OFS_TRIG_SEL    8'h20
`define OFS_TRIG_CFG    8'h24
`define OFS_TRIG_DELAY  8'h28
`define OFS_STATUS      8'h2c
`define CMD_BEGIN_BIT   0
`define CMD_END_BIT     1
`define CMD_SOFT_BIT    2
`define RST_MULTI_CNT   16'h0001
`define RST_BURST_CNT   16'h0001
`define RST_EXPOSURE_US 24'h0003e8
`define RST_RATE_REQ    16'h001e
`define RST_DELAY_US    24'h000000
`define CLK_MHZ         250
`define US_CYCLES       (`CLK_MHZ)
`define READOUT_CYCLES  16'h0400
`define AUTO_ONCE_CYC   16'h0100
`define ONE_HZ_CYCLES   32'd250000000
`endif

// file: rtl/capture_ctrl_pkg.sv
// Types shared by the capture control logic.
package capture_ctrl_pkg;
    typedef enum logic [1:0] {
        CAP_CONT = 2'b00, CAP_SINGLE = 2'b01, CAP_MULTI = 2'b10
    } capture_mode_t;
    typedef enum logic [1:0] {
        AE_OFF = 2'b00, AE_ONCE = 2'b01, AE_CONT = 2'b10
    } auto_exposure_t;
    typedef enum logic [1:0] {
        TT_BEGIN = 2'b00, TT_FRAME = 2'b01, TT_BURST = 2'b10
    } trig_type_t;
    typedef enum logic [2:0] {
        QL_LOW = 3'b000, QL_HIGH = 3'b001, QL_FALL = 3'b010,
        QL_RISE = 3'b011, QL_ANY = 3'b100
    } trig_qual_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_ARMED = 2'b01, ST_DELAY = 2'b10,
        ST_EXPOSE = 2'b11
    } cap_state_t;
    typedef struct packed {
        logic       enable;
        logic [3:0] origin;
        trig_qual_t qual;
        logic       overlap;
    } trig_cfg_t;
    typedef struct packed {
        logic [3:0] lines;
        logic [3:0] user_out;
        logic [3:0] counter_evt;
        logic [1:0] logic_blk;
    } trig_inputs_t;
endpackage

// file: sim/trig_line_model.sv
// Model of the external trigger lines that feed the capture block.
`timescale 1ns/1ps
module trig_line_model
    import capture_ctrl_pkg::*;
(
    input  wire logic   hclk,
    output trig_inputs_t trig_in
);
    initial trig_in = '0;

    // Holds one line high for the given number of cycles: one rising edge.
    task automatic fire(input int idx, input int width);
        @(posedge hclk);
        trig_in.lines[idx] <= 1'b1;
        repeat (width) @(posedge hclk);
        trig_in.lines[idx] <= 1'b0;
    endtask
endmodule // trig_line_model

// file: sim/capture_ctrl_tb_top.sv
// Self-checking testbench for the capture control block.
`timescale 1ns/1ps
`include "capture_ctrl_defs.svh"
module capture_ctrl_tb_top;
    import capture_ctrl_pkg::*;
    logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic         exposing, readout_busy, frame_done, exp_q, line_q;
    logic [31:0]  haddr, hwdata, hrdata, v;
    logic [1:0]   htrans;
    logic [2:0]   hsize;
    trig_inputs_t trig_in;
    int           n_mismatch, samples_checked, n_frames, f0;
    int           cyc, t_rise, t_exp, exp_len, len_q;

    capture_ctrl i_capture_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .trig_in(trig_in),
        .exposing(exposing), .readout_busy(readout_busy),
        .frame_done(frame_done));
    trig_line_model i_trig_line_model (.hclk(hclk), .trig_in(trig_in));

    initial hclk = 1'b0;
    always #2 hclk = ~hclk;

    // ****************************************************************
    // Observers of frames, exposure length and trigger-to-exposure time
    // ****************************************************************
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        line_q <= trig_in.lines[0];
        exp_q <= exposing;
        if (frame_done === 1'b1) n_frames <= n_frames + 1;
        if (trig_in.lines[0] === 1'b1 && line_q !== 1'b1) t_rise <= cyc;
        if (exposing === 1'b1 && exp_q !== 1'b1) t_exp <= cyc;
        if (exposing === 1'b1) len_q <= len_q + 1;
        else if (exp_q === 1'b1) begin
            exp_len <= len_q;
            len_q <= 0;
        end
    end

    // ****************************************************************
    // Bus and check tasks
    // ****************************************************************
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 100);
        if (k >= 100) begin
            n_mismatch++;
            conclude();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        wait_ready();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, v);
        check(v, exp);
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic wait_idle();
        int k;
        k = 0;
        cycles(2);
        do begin
            bus(1'b0, `OFS_STATUS, 32'h0, v);
            k++;
        end while (v[1:0] !== 2'b00 && k < 3000);
        if (k >= 3000) begin
            n_mismatch++;
            conclude();
        end
    endtask

    task automatic wait_frames(input int n);
        int k;
        for (k = 0; k < 10000 && n_frames < n; k++) @(posedge hclk);
        if (n_frames < n) begin
            n_mismatch++;
            conclude();
        end
    endtask

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        {n_mismatch, samples_checked, n_frames, cyc, len_q} = '0;
        {t_rise, t_exp, exp_len, exp_q, line_q} = '0;
        hresetn = 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk(`OFS_MODE, 32'h08);
        rdchk(`OFS_RATE_CTRL, 32'h0);
        rdchk(`OFS_TRIG_CFG, 32'h6);
        rdchk(`OFS_TRIG_SEL, 32'h0);
        rdchk(8'h40, 32'h0);
        rdchk(`OFS_RATE_ACT, 32'd1000);
        $display("test reset_values done");
        wr(`OFS_MODE, 32'h04);
        cycles(300);
        rdchk(`OFS_MODE, 32'h0);
        $display("test auto_once done");
        wr(`OFS_EXPOSURE, 32'h1);
        wr(`OFS_RATE_CTRL, 32'h1);
        cycles(4);
        rdchk(`OFS_RATE_ACT, 32'd30);
        wr(`OFS_RATE_ACT, 32'h55);
        rdchk(`OFS_RATE_ACT, 32'd30);
        wr(`OFS_EXPOSURE, 32'h10000);
        cycles(4);
        bus(1'b0, `OFS_RATE_ACT, 32'h0, v);
        check({31'h0, v < 32'd30}, 32'h1);
        wr(`OFS_EXPOSURE, 32'h1);
        $display("test frame_rate done");
        wr(`OFS_MODE, 32'h01);
        f0 = n_frames;
        wr(`OFS_COMMAND, 32'h1);
        wait_idle();
        cycles(1100);
        check(n_frames - f0, 32'd1);
        check(exp_len, 32'd250);
        wr(`OFS_MULTI_CNT, 32'd3);
        wr(`OFS_MODE, 32'h02);
        f0 = n_frames;
        wr(`OFS_COMMAND, 32'h1);
        wait_idle();
        cycles(1100);
        check(n_frames - f0, 32'd3);
        $display("test counted_modes done");
        wr(`OFS_MULTI_CNT, 32'd5);
        f0 = n_frames;
        wr(`OFS_COMMAND, 32'h1);
        wait_frames(f0 + 1);
        wr(`OFS_COMMAND, 32'h2);
        cycles(2);
        bus(1'b0, `OFS_STATUS, 32'h0, v);
        check({29'h0, v[2:0]}, 32'h0);
        f0 = n_frames;
        cycles(3000);
        check(n_frames - f0, 32'd0);
        wr(`OFS_MODE, 32'h00);
        f0 = n_frames;
        wr(`OFS_COMMAND, 32'h1);
        wait_frames(f0 + 3);
        wr(`OFS_COMMAND, 32'h2);
        cycles(1100);
        f0 = n_frames;
        cycles(3000);
        check(n_frames - f0, 32'd0);
        $display("test begin_end done");
        wr(`OFS_TRIG_SEL, 32'h1);
        wr(`OFS_TRIG_CFG, 32'h1e6);
        wr(`OFS_COMMAND, 32'h1);
        f0 = n_frames;
        cycles(2000);
        check(n_frames - f0, 32'd0);
        wr(`OFS_COMMAND, 32'h4);
        cycles(2000);
        check(n_frames - f0, 32'd1);
        wr(`OFS_COMMAND, 32'h4);
        cycles(2000);
        check(n_frames - f0, 32'd2);
        f0 = n_frames;
        wr(`OFS_COMMAND, 32'h4);
        cycles(300);
        wr(`OFS_COMMAND, 32'h4);
        cycles(2000);
        check(n_frames - f0, 32'd1);
        wr(`OFS_TRIG_CFG, 32'h1e7);
        f0 = n_frames;
        wr(`OFS_COMMAND, 32'h4);
        cycles(300);
        wr(`OFS_COMMAND, 32'h4);
        cycles(2000);
        check(n_frames - f0, 32'd2);
        wr(`OFS_TRIG_CFG, 32'h106);
        wr(`OFS_TRIG_DELAY, 32'd2);
        f0 = n_frames;
        wr(`OFS_COMMAND, 32'h4);
        cycles(2000);
        check(n_frames - f0, 32'd0);
        i_trig_line_model.fire(0, 4);
        cycles(2000);
        check(n_frames - f0, 32'd1);
        check({31'h0, (t_exp - t_rise) inside {[500:508]}}, 32'h1);
        wr(`OFS_TRIG_DELAY, 32'd0);
        wr(`OFS_MODE, 32'h20);
        i_trig_line_model.fire(0, 40);
        cycles(2000);
        check({31'h0, exp_len inside {[38:41]}}, 32'h1);
        wr(`OFS_MODE, 32'h00);
        $display("test frame_trigger done");
        wr(`OFS_TRIG_SEL, 32'h2);
        wr(`OFS_BURST_CNT, 32'd2);
        wr(`OFS_TRIG_CFG, 32'h1e6);
        f0 = n_frames;
        wr(`OFS_COMMAND, 32'h4);
        cycles(5000);
        check(n_frames - f0, 32'd2);
        $display("test burst_trigger done");
        wr(`OFS_TRIG_CFG, 32'h0e6);
        wr(`OFS_TRIG_SEL, 32'h1);
        wr(`OFS_TRIG_CFG, 32'h1e6);
        wr(`OFS_COMMAND, 32'h2);
        wr(`OFS_MODE, 32'h01);
        wr(`OFS_COMMAND, 32'h1);
        f0 = n_frames;
        wr(`OFS_COMMAND, 32'h4);
        cycles(2000);
        wr(`OFS_COMMAND, 32'h4);
        cycles(2000);
        check(n_frames - f0, 32'd1);
        wr(`OFS_COMMAND, 32'h1);
        wr(`OFS_COMMAND, 32'h4);
        cycles(2000);
        check(n_frames - f0, 32'd2);
        $display("test single_trigger done");
        wr(`OFS_TRIG_CFG, 32'h0e6);
        wr(`OFS_TRIG_SEL, 32'h0);
        wr(`OFS_TRIG_CFG, 32'h1e6);
        wr(`OFS_MODE, 32'h00);
        wr(`OFS_COMMAND, 32'h1);
        f0 = n_frames;
        cycles(1000);
        check(n_frames - f0, 32'd0);
        wr(`OFS_COMMAND, 32'h4);
        wait_frames(f0 + 3);
        wr(`OFS_COMMAND, 32'h2);
        $display("test begin_trigger done");
        conclude();
    end
endmodule // capture_ctrl_tb_top
